// [rtl/ucr_de_timer.sv]
`timescale 1ns/1ns
module ucr_de_timer import ucr_pkg::*; #(
    parameter int W = UCR_DE_W
) (
    input wire logic ref_clk, // clock
    input wire logic resetn, // async reset, low
    input wire logic sample_tick, // one sample time elapsed
    input wire logic [W-1:0] lead, // ticks from enable to start bit
    input wire logic [W-1:0] lag, // ticks from stop bit end to release
    input wire logic data_written, // new transmit data pulse
    input wire logic frame_done, // end of last stop bit pulse
    output logic driver_enable, // external driver enable
    output logic tx_start // start bit may begin, one cycle
);
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SEND, ST_LAG} ucr_de_state_t;
    ucr_de_state_t state;
    ucr_de_state_t next_state;
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic pending;
    logic go;
    logic lead_done;
    logic lag_done;

    if (W < 1) begin : g_chk
        $error("ucr_de_timer needs a nonzero field width");
    end

    assign go = data_written | pending;
    assign lead_done = sample_tick && (cnt + 1'b1 >= lead);
    assign lag_done = sample_tick && (cnt + 1'b1 >= lag);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            ST_IDLE: begin
                next_cnt = '0;
                if (go) begin
                    next_state = (lead == '0) ? ST_SEND : ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (lead_done) begin
                    next_state = ST_SEND;
                end else if (sample_tick) begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_SEND: begin
                next_cnt = '0;
                if (frame_done) begin
                    next_state = (lag == '0) ? ST_IDLE : ST_LAG;
                end
            end
            ST_LAG: begin
                if (lag_done) begin
                    next_state = ST_IDLE;
                end else if (sample_tick) begin
                    next_cnt = cnt + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // writes outside the lag interval belong to the data path's own queue
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pending <= 1'b0;
        end else if (state == ST_LAG && data_written) begin
            pending <= 1'b1;
        end else if (state == ST_IDLE) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            driver_enable <= 1'b0;
            tx_start <= 1'b0;
        end else begin
            driver_enable <= (next_state != ST_IDLE);
            tx_start <= (next_state == ST_SEND) && (state != ST_SEND);
        end
    end

    property p_start_with_de;
        @(posedge ref_clk) disable iff (!resetn)
        tx_start |-> driver_enable;
    endproperty
    a_start_with_de: assert property (p_start_with_de) else $error("start bit without driver enable");

    property p_lag_no_start;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ST_LAG && !lag_done) |=> !tx_start;
    endproperty
    a_lag_no_start: assert property (p_lag_no_start) else $error("start during lag interval");

    property p_pending_waits_lead;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ST_LAG && lag_done && (pending || data_written) && lead != '0) |=> ##1 (state == ST_LEAD);
    endproperty
    a_pending_waits_lead: assert property (p_pending_waits_lead) else $error("held data skipped lead");
endmodule : ucr_de_timer

// [rtl/ucr_pkg.sv]
// Functional notes
// - control word one sits at offset 0x00, resets to zero, bit 1 reserved.
// - receive queue full flag raises the interrupt only while its enable is set.
// - transmit queue empty flag raises the interrupt only while its enable is set.
// - bit 29 enables the transmit and receive queues.
// - queue mode bit changes only while the peripheral enable is zero.
// - word length code is bit 28 high, bit 12 low: 8, 9, 7 bits.
// - upper word length bit changes only while the peripheral enable is zero.
// - block end flag raises the interrupt only while its enable is set.
// - without smartcard support the block end enable stays zero.
// - receiver timeout flag raises the interrupt only while its enable is set.
// - bit 15 picks 16 or 8 samples per bit, locked while enabled.
// - data written during the lag interval waits for lag then lead.
// - bits 25:21 and 20:16 give driver lead and lag in sample units.
package ucr_pkg;
    localparam int UCR_ADDR_W = 12;
    localparam logic [11:0] UCR_CR1_OFF = 12'h000;
    localparam logic [11:0] UCR_STATUS_OFF = 12'h004;
    localparam logic [11:0] UCR_MASK_OFF = 12'h008;

    localparam logic [1:0] UCR_SEL_CR1 = 2'h0;
    localparam logic [1:0] UCR_SEL_STATUS = 2'h1;
    localparam logic [1:0] UCR_SEL_MASK = 2'h2;
    localparam logic [1:0] UCR_SEL_NONE = 2'h3;

    localparam int UCR_RX_FULL_EN_BIT = 31;
    localparam int UCR_TX_EMPTY_EN_BIT = 30;
    localparam int UCR_QUEUE_EN_BIT = 29;
    localparam int UCR_WLHI_BIT = 28;
    localparam int UCR_BLOCK_END_EN_BIT = 27;
    localparam int UCR_TIMEOUT_EN_BIT = 26;
    localparam int UCR_LEAD_LSB = 21;
    localparam int UCR_LAG_LSB = 16;
    localparam int UCR_DE_W = 5;
    localparam int UCR_OVERSAMPLE_BIT = 15;
    localparam int UCR_WLLO_BIT = 12;
    localparam int UCR_RSVD_BIT = 1;
    localparam int UCR_PERIPH_EN_BIT = 0;

    localparam logic [31:0] UCR_CR1_RESET = 32'h0000_0000;
    localparam logic [31:0] UCR_CR1_WRITABLE = 32'hffff_fffd;
    // fields frozen while the peripheral enable is set
    localparam logic [31:0] UCR_CR1_LOCKED = 32'h33ff_8000;

    localparam int UCR_EV_N = 4;
    localparam int UCR_EV_RX_FULL = 3;
    localparam int UCR_EV_TX_EMPTY = 2;
    localparam int UCR_EV_BLOCK_END = 1;
    localparam int UCR_EV_RX_TIMEOUT = 0;
    localparam logic [3:0] UCR_STATUS_RESET = 4'h0;
    localparam logic [3:0] UCR_MASK_RESET = 4'hf;

    localparam logic [1:0] UCR_WL_8 = 2'h0;
    localparam logic [1:0] UCR_WL_9 = 2'h1;
    localparam logic [1:0] UCR_WL_7 = 2'h2;

    typedef struct packed {
        logic rx_queue_full_flag;
        logic tx_queue_empty_flag;
        logic block_end_flag;
        logic rx_timeout_flag;
    } ucr_event_t;

    typedef struct packed {
        logic rx_queue_full_irq_enable;
        logic tx_queue_empty_irq_enable;
        logic queue_mode_enable;
        logic [1:0] word_length;
        logic block_end_irq_enable;
        logic rx_timeout_irq_enable;
        logic [4:0] driver_lead_time;
        logic [4:0] driver_lag_time;
        logic oversample_select;
        logic peripheral_enable;
    } ucr_cfg_t;

    function automatic logic [1:0] ucr_decode(input logic [11:0] a);
        if (a == UCR_CR1_OFF) begin
            return UCR_SEL_CR1;
        end else if (a == UCR_STATUS_OFF) begin
            return UCR_SEL_STATUS;
        end else if (a == UCR_MASK_OFF) begin
            return UCR_SEL_MASK;
        end
        return UCR_SEL_NONE;
    endfunction : ucr_decode
endpackage : ucr_pkg

// [rtl/ucr_sticky.sv]
`timescale 1ns/1ns
module ucr_sticky #(
    parameter int N = 4
) (
    input wire logic ref_clk, // clock
    input wire logic resetn, // async reset, low
    input wire logic [N-1:0] set, // event pulses
    input wire logic [N-1:0] clr, // write-one-to-clear strobes
    output logic [N-1:0] flags // sticky flags
);
    if (N < 1) begin : g_chk
        $error("ucr_sticky needs at least one flag");
    end

    for (genvar i = 0; i < N; i++) begin : g_flag
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                flags[i] <= 1'b0;
            end else if (set[i]) begin
                // an event in the clearing cycle is kept
                flags[i] <= 1'b1;
            end else if (clr[i]) begin
                flags[i] <= 1'b0;
            end
        end
    end
endmodule : ucr_sticky

// [rtl/ucr_top.sv]
`timescale 1ns/1ns
module ucr_top import ucr_pkg::*; #(
    parameter bit SMARTCARD_SUPPORT = 1'b1,
    parameter bit RX_TIMEOUT_SUPPORT = 1'b1,
    parameter int APB_ADDR_W = UCR_ADDR_W
) (
    input wire logic ref_clk, // 20 MHz clock
    input wire logic resetn, // async reset, low
    input wire logic [APB_ADDR_W-1:0] paddr, // APB byte address
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire ucr_event_t events, // status event pulses from the data path
    input wire logic sample_tick, // one sample time
    input wire logic tx_data_written, // transmit data register written
    input wire logic frame_done, // last stop bit ended
    output ucr_cfg_t cfg, // decoded control fields
    output logic irq, // level interrupt
    output logic driver_enable, // external driver enable
    output logic tx_start // start bit go pulse
);
    logic [31:0] cr1;
    logic [UCR_EV_N-1:0] mask;
    logic [UCR_EV_N-1:0] status;
    logic [UCR_EV_N-1:0] enables;
    logic [UCR_EV_N-1:0] clr;
    logic [1:0] sel;
    logic done;
    logic wr;
    logic rd_phase;
    logic [31:0] rdval;

    if (APB_ADDR_W < UCR_ADDR_W) begin : g_chk
        $error("ucr_top needs at least twelve address bits");
    end

    function automatic logic [31:0] ucr_cr1_apply(input logic [31:0] old, input logic [31:0] wd);
        logic [31:0] v;
        v = wd & UCR_CR1_WRITABLE;
        if (old[UCR_PERIPH_EN_BIT]) begin
            v = (v & ~UCR_CR1_LOCKED) | (old & UCR_CR1_LOCKED);
        end
        if (!SMARTCARD_SUPPORT) begin
            v[UCR_BLOCK_END_EN_BIT] = 1'b0;
        end
        if (!RX_TIMEOUT_SUPPORT) begin
            v[UCR_TIMEOUT_EN_BIT] = 1'b0;
        end
        return v;
    endfunction : ucr_cr1_apply

    assign sel = ucr_decode(paddr[UCR_ADDR_W-1:0]);
    assign done = psel && penable && pready;
    assign wr = done && pwrite;
    assign rd_phase = psel && penable && !pready;

    // one wait state: ready rises in the second access cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_phase;
            pslverr <= rd_phase && (sel == UCR_SEL_NONE);
        end
    end

    always_comb begin
        rdval = 32'h0000_0000;
        unique case (sel)
            UCR_SEL_CR1: rdval = cr1;
            UCR_SEL_STATUS: rdval = {28'h000_0000, status};
            UCR_SEL_MASK: rdval = {28'h000_0000, mask};
            UCR_SEL_NONE: rdval = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_phase) begin
            prdata <= pwrite ? 32'h0000_0000 : rdval;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cr1 <= UCR_CR1_RESET;
        end else if (wr && sel == UCR_SEL_CR1) begin
            cr1 <= ucr_cr1_apply(cr1, pwdata);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mask <= UCR_MASK_RESET;
        end else if (wr && sel == UCR_SEL_MASK) begin
            mask <= pwdata[UCR_EV_N-1:0];
        end
    end

    assign clr = (wr && sel == UCR_SEL_STATUS) ? pwdata[UCR_EV_N-1:0] : '0;

    ucr_sticky #(
        .N(UCR_EV_N)
    ) u_status (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .set(events),
        .clr(clr),
        .flags(status)
    );

    // status bit order matches the enable order in the control word
    assign enables = {cr1[UCR_RX_FULL_EN_BIT], cr1[UCR_TX_EMPTY_EN_BIT],
        cr1[UCR_BLOCK_END_EN_BIT], cr1[UCR_TIMEOUT_EN_BIT]};

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & enables & mask);
        end
    end

    always_comb begin
        cfg.rx_queue_full_irq_enable = cr1[UCR_RX_FULL_EN_BIT];
        cfg.tx_queue_empty_irq_enable = cr1[UCR_TX_EMPTY_EN_BIT];
        cfg.queue_mode_enable = cr1[UCR_QUEUE_EN_BIT];
        cfg.word_length = {cr1[UCR_WLHI_BIT], cr1[UCR_WLLO_BIT]};
        cfg.block_end_irq_enable = cr1[UCR_BLOCK_END_EN_BIT];
        cfg.rx_timeout_irq_enable = cr1[UCR_TIMEOUT_EN_BIT];
        cfg.driver_lead_time = cr1[UCR_LEAD_LSB +: UCR_DE_W];
        cfg.driver_lag_time = cr1[UCR_LAG_LSB +: UCR_DE_W];
        cfg.oversample_select = cr1[UCR_OVERSAMPLE_BIT];
        cfg.peripheral_enable = cr1[UCR_PERIPH_EN_BIT];
    end

    ucr_de_timer #(
        .W(UCR_DE_W)
    ) u_de (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .sample_tick(sample_tick),
        .lead(cr1[UCR_LEAD_LSB +: UCR_DE_W]),
        .lag(cr1[UCR_LAG_LSB +: UCR_DE_W]),
        .data_written(tx_data_written),
        .frame_done(frame_done),
        .driver_enable(driver_enable),
        .tx_start(tx_start)
    );

    property p_lock;
        @(posedge ref_clk) disable iff (!resetn)
        (wr && sel == UCR_SEL_CR1 && cr1[UCR_PERIPH_EN_BIT])
        |=> ((cr1 & UCR_CR1_LOCKED) == ($past(cr1) & UCR_CR1_LOCKED));
    endproperty
    a_lock: assert property (p_lock) else $error("locked field changed while enabled");

    property p_queue_mode_write;
        @(posedge ref_clk) disable iff (!resetn)
        (wr && sel == UCR_SEL_CR1 && !cr1[UCR_PERIPH_EN_BIT])
        |=> ((cr1 & UCR_CR1_LOCKED) == ($past(pwdata) & UCR_CR1_LOCKED))
            && (cfg.queue_mode_enable == $past(pwdata[UCR_QUEUE_EN_BIT]));
    endproperty
    a_queue_mode_write: assert property (p_queue_mode_write) else $error("unlocked write not stored");

    property p_rx_full_irq;
        @(posedge ref_clk) disable iff (!resetn)
        (status[UCR_EV_RX_FULL] && cr1[UCR_RX_FULL_EN_BIT] && mask[UCR_EV_RX_FULL]) |=> irq;
    endproperty
    a_rx_full_irq: assert property (p_rx_full_irq) else $error("receive full interrupt missing");

    property p_tx_empty_irq;
        @(posedge ref_clk) disable iff (!resetn)
        (status[UCR_EV_TX_EMPTY] && cr1[UCR_TX_EMPTY_EN_BIT] && mask[UCR_EV_TX_EMPTY]) |=> irq;
    endproperty
    a_tx_empty_irq: assert property (p_tx_empty_irq) else $error("transmit empty interrupt missing");

    property p_block_end_irq;
        @(posedge ref_clk) disable iff (!resetn)
        (status[UCR_EV_BLOCK_END] && cr1[UCR_BLOCK_END_EN_BIT] && mask[UCR_EV_BLOCK_END]) |=> irq;
    endproperty
    a_block_end_irq: assert property (p_block_end_irq) else $error("block end interrupt missing");

    property p_timeout_irq;
        @(posedge ref_clk) disable iff (!resetn)
        (status[UCR_EV_RX_TIMEOUT] && cr1[UCR_TIMEOUT_EN_BIT] && mask[UCR_EV_RX_TIMEOUT]) |=> irq;
    endproperty
    a_timeout_irq: assert property (p_timeout_irq) else $error("timeout interrupt missing");

    property p_no_irq;
        @(posedge ref_clk) disable iff (!resetn)
        ((status & mask & {cfg.rx_queue_full_irq_enable, cfg.tx_queue_empty_irq_enable,
            cfg.block_end_irq_enable, cfg.rx_timeout_irq_enable}) == '0) |=> !irq;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("interrupt without enabled cause");

    property p_block_end_held;
        @(posedge ref_clk) disable iff (!resetn)
        !SMARTCARD_SUPPORT |-> !cr1[UCR_BLOCK_END_EN_BIT];
    endproperty
    a_block_end_held: assert property (p_block_end_held) else $error("block end enable set without support");

    property p_reserved_read;
        @(posedge ref_clk) disable iff (!resetn)
        (rd_phase && !pwrite && sel == UCR_SEL_CR1) |=> (pready && !prdata[UCR_RSVD_BIT] && prdata == cr1);
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("control word read wrong");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (!resetn)
        (wr && sel == UCR_SEL_CR1) |=> !cr1[UCR_RSVD_BIT];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved control bit stored");

    property p_word_length;
        @(posedge ref_clk) disable iff (!resetn)
        (wr && sel == UCR_SEL_CR1 && !cr1[UCR_PERIPH_EN_BIT])
        |=> (cfg.word_length == {$past(pwdata[UCR_WLHI_BIT]), $past(pwdata[UCR_WLLO_BIT])});
    endproperty
    a_word_length: assert property (p_word_length) else $error("word length code not stored");

    property p_unmapped;
        @(posedge ref_clk) disable iff (!resetn)
        (rd_phase && sel == UCR_SEL_NONE) |=> (pready && pslverr && prdata == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_ready_pulse;
        @(posedge ref_clk) disable iff (!resetn)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past one cycle");

    // set must win over a clear in the same cycle
    property p_event_sets;
        @(posedge ref_clk) disable iff (!resetn)
        (events != '0) |=> ((status & $past(events)) == $past(events));
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event lost in status");

    property p_status_clear;
        @(posedge ref_clk) disable iff (!resetn)
        (clr != '0 && events == '0) |=> ((status & $past(clr)) == '0);
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status bit not cleared");

    property p_mask_write;
        @(posedge ref_clk) disable iff (!resetn)
        (wr && sel == UCR_SEL_MASK) |=> (mask == $past(pwdata[UCR_EV_N-1:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

    property p_start_pulse;
        @(posedge ref_clk) disable iff (!resetn)
        tx_start |=> !tx_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse longer than a cycle");
endmodule : ucr_top

// [tb/tb.sv]
`timescale 1ns/1ns
module tb import ucr_pkg::*; ();
    logic ref_clk, resetn, psel, penable, pwrite, tx_data_written, pready, pslverr, irq, driver_enable, tx_start;
    logic sample_tick, frame_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    ucr_event_t events;
    ucr_cfg_t cfg, cfg2;
    int fail_count, checked;

    ucr_top dut (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
        .sample_tick(sample_tick), .tx_data_written(tx_data_written), .frame_done(frame_done), .cfg(cfg),
        .irq(irq), .driver_enable(driver_enable), .tx_start(tx_start));
    // second build without smartcard, register view only
    ucr_top #(.SMARTCARD_SUPPORT(1'b0)) dut_nosc (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .events(events), .sample_tick(sample_tick), .tx_data_written(tx_data_written), .frame_done(frame_done),
        .cfg(cfg2), .irq(), .driver_enable(), .tx_start());
    ucr_line_model line (.ref_clk(ref_clk), .resetn(resetn), .tx_start(tx_start), .sample_tick(sample_tick),
        .frame_done(frame_done));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bound(input int n);
        if (n > 500) begin
            fail_count++;
            end_sim();
        end
    endtask : bound

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n <= 500; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        bound(n);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd

    task automatic t_regs;
        logic [31:0] r;
        logic e;
        logic [1:0] wl;
        rd(UCR_CR1_OFF, r);
        chk(r, 32'h0000_0000);
        chk(cfg, 32'h0);
        wr(UCR_CR1_OFF, 32'hffff_fffe);
        rd(UCR_CR1_OFF, r);
        chk(r, 32'hffff_fffc);
        chk(cfg.queue_mode_enable, 1'b1);
        chk(cfg.oversample_select, 1'b1);
        chk({cfg.driver_lead_time, cfg.driver_lag_time}, 10'h3ff);
        chk(cfg, 32'h0007_fffe);
        chk({cfg2.block_end_irq_enable, cfg2.rx_timeout_irq_enable}, 2'h1);
        apb(1'b0, 12'h00c, 32'h0, r, e);
        chk(e, 1'b1);
        chk(r, 32'h0000_0000);
        wr(UCR_CR1_OFF, 32'h0000_0002);
        rd(UCR_CR1_OFF, r);
        chk(r, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            wl = 2'(k);
            wr(UCR_CR1_OFF, {3'h0, wl[1], 15'h0, wl[0], 12'h0});
            cyc(1);
            chk(cfg.word_length, wl);
        end
    endtask : t_regs

    task automatic t_lock;
        logic [31:0] r;
        wr(UCR_CR1_OFF, 32'h0000_0001);
        wr(UCR_CR1_OFF, 32'h33ff_8001);
        rd(UCR_CR1_OFF, r);
        chk(r, 32'h0000_0001);
        chk(cfg.peripheral_enable, 1'b1);
        wr(UCR_CR1_OFF, 32'h0000_0000);
        wr(UCR_CR1_OFF, 32'h3000_0000);
        rd(UCR_CR1_OFF, r);
        chk(r, 32'h3000_0000);
        wr(UCR_CR1_OFF, 32'h0000_0000);
    endtask : t_lock

    task automatic pulse_ev(input int i);
        @(posedge ref_clk);
        events <= ucr_event_t'(4'h1 << i);
        @(posedge ref_clk);
        events <= ucr_event_t'(4'h0);
    endtask : pulse_ev

    task automatic t_irq;
        int en_bit[4] = '{26, 27, 30, 31};
        logic [31:0] r;
        for (int i = 0; i < 4; i++) begin
            // queue interrupt enables only with queue mode on
            wr(UCR_CR1_OFF, (32'h1 << en_bit[i]) | ((i >= 2) ? 32'h2000_0000 : 32'h0));
            pulse_ev(i);
            cyc(3);
            chk(irq, 1'b1);
            wr(UCR_MASK_OFF, 32'h0);
            cyc(2);
            chk(irq, 1'b0);
            wr(UCR_MASK_OFF, 32'hf);
            cyc(2);
            chk(irq, 1'b1);
            wr(UCR_STATUS_OFF, 32'h1 << i);
            cyc(2);
            chk(irq, 1'b0);
            wr(UCR_CR1_OFF, 32'h0);
            pulse_ev(i);
            cyc(3);
            chk(irq, 1'b0);
            rd(UCR_STATUS_OFF, r);
            chk(r, 32'h1 << i);
            wr(UCR_STATUS_OFF, 32'h1 << i);
        end
    endtask : t_irq

    task automatic pulse_tx;
        @(posedge ref_clk);
        tx_data_written <= 1'b1;
        @(posedge ref_clk);
        tx_data_written <= 1'b0;
    endtask : pulse_tx

    // lead ticks are counted from the last low cycle of the driver enable
    task automatic wait_start(output int t, output logic low);
        int n;
        t = 0;
        low = 1'b0;
        for (n = 0; n <= 500; n++) begin
            @(posedge ref_clk);
            if (tx_start === 1'b1) break;
            if (driver_enable !== 1'b1) begin
                low = 1'b1;
                t = 0;
            end else if (sample_tick === 1'b1) begin
                t++;
            end
        end
        bound(n);
    endtask : wait_start

    task automatic wait_done;
        int n;
        for (n = 0; n <= 500; n++) begin
            @(posedge ref_clk);
            if (frame_done === 1'b1) break;
        end
        bound(n);
    endtask : wait_done

    task automatic t_de;
        int t;
        int n;
        logic low;
        wr(UCR_CR1_OFF, 32'h0043_0000);
        pulse_tx();
        wait_start(t, low);
        chk(t, 32'd2);
        wait_done();
        t = 0;
        for (n = 0; n <= 500; n++) begin
            @(posedge ref_clk);
            if (driver_enable !== 1'b1) break;
            if (sample_tick === 1'b1) t++;
        end
        bound(n);
        chk(t, 32'd3);
        pulse_tx();
        wait_start(t, low);
        wait_done();
        pulse_tx();
        wait_start(t, low);
        chk({low, t[3:0]}, 5'h12);
        wait_done();
        cyc(30);
        chk(driver_enable, 1'b0);
        // zero lead and lag: start with the enable, release right after the frame
        wr(UCR_CR1_OFF, 32'h0000_0000);
        pulse_tx();
        wait_start(t, low);
        chk({low, t[3:0]}, 5'h00);
        wait_done();
        cyc(1);
        chk(driver_enable, 1'b0);
    endtask : t_de

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        tx_data_written = 1'b0;
        events = ucr_event_t'(4'h0);
        fail_count = 0;
        checked = 0;
        cyc(10);
        resetn <= 1'b1;
        t_regs();
        t_lock();
        t_irq();
        t_de();
        end_sim();
    end
endmodule : tb

// [tb/ucr_line_model.sv]
`timescale 1ns/1ns
module ucr_line_model #(
    parameter int TICK_DIV = 4,
    parameter int FRAME_LEN = 24
) (
    input wire logic ref_clk, // clock
    input wire logic resetn, // async reset, low
    input wire logic tx_start, // start bit go
    output logic sample_tick, // one sample time
    output logic frame_done // last stop bit ended
);
    int div;
    int left;
    // free running, like the baud generator of the data path
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            div <= 0;
            sample_tick <= 1'b0;
        end else begin
            div <= (div == TICK_DIV - 1) ? 0 : div + 1;
            sample_tick <= (div == TICK_DIV - 1);
        end
    end
    // fixed frame length; a start during a frame restarts it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            left <= 0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= (left == 1);
            if (tx_start) begin
                left <= FRAME_LEN;
            end else if (left > 0) begin
                left <= left - 1;
            end
        end
    end
endmodule : ucr_line_model
